// ==== hdl/lat_sel_pkg.sv ====
// Package for the read latency selector: table values, command families.
// Assumes nothing of its surroundings beyond a SystemVerilog compiler.
`default_nettype none
package lat_sel_pkg;
    localparam logic [7:0] CNT_NA = 8'hff;
    localparam logic [1:0] LC_00  = 2'h0;
    localparam logic [1:0] LC_01  = 2'h1;
    localparam logic [1:0] LC_10  = 2'h2;
    localparam logic [1:0] LC_11  = 2'h3;
    localparam int FREQ_LC11_MHZ    = 50;
    localparam int FREQ_LC00_MHZ    = 80;
    localparam int FREQ_LC01_MHZ    = 90;
    localparam int FREQ_LC10_MHZ    = 108;
    localparam int FREQ_LC10_HI_MHZ = 133;
    localparam logic [7:0] MODE_NONE = 8'h00;
    localparam logic [7:0] MODE_DIO  = 8'h04;
    localparam logic [7:0] MODE_QIO  = 8'h02;
    localparam logic [7:0] DMY_NONE  = 8'h00;
    localparam logic [7:0] DMY_STD   = 8'h08;
    localparam logic [7:0] DMY_QIO11 = 8'h01;
    localparam logic [7:0] DMY_DIO01 = 8'h01;
    localparam logic [7:0] DMY_QIO01 = 8'h04;
    localparam logic [7:0] DMY_DIO10 = 8'h02;
    localparam logic [7:0] DMY_QIO10 = 8'h05;
    typedef enum logic [2:0] {
        FAM_READ = 3'h0,
        FAM_FAST = 3'h1,
        FAM_DOUT = 3'h2,
        FAM_QOUT = 3'h3,
        FAM_DIO  = 3'h4,
        FAM_QIO  = 3'h5
    } fam_t;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_MODE  = 2'b01,
        ST_DUMMY = 2'b11,
        ST_DATA  = 2'b10
    } phase_t;
endpackage
`default_nettype wire

// ==== hdl/read_latency_code_selector.sv ====
// Read latency selector: picks mode and dummy counts, then paces them on SCK.
// Assumes the command decoder marks the end of the address phase on SCK.
//
// Summary of operation
// RULE1: Code 11b: dual/quad out none; dual I/O 4 mode; quad I/O 2+1.
// RULE2: Code 11b timings hold only up to 50 MHz SCK.
// RULE3: Code 00b up to 80 MHz: basic read unsupported, fast read 8 dummy.
// RULE4: Code 01b up to 90 MHz: outs 8 dummy, dual I/O 4+1, quad 2+4.
// RULE5: Code 10b up to 108 MHz: outs 8 dummy, dual I/O 4+2, quad 2+5.
// RULE6: Code 10b above 108 MHz up to 133 MHz: only fast read, 8 dummy.
// RULE7: A count of all ones marks the command unavailable in that band.
// RULE8: Mode then dummy clocks follow the address; data is driven afterwards.
`default_nettype none
module read_latency_code_selector
    import lat_sel_pkg::*;
(
    // System clock domain.
    input  wire logic       mclk_i,
    input  wire logic       srst_i,
    input  wire logic [1:0] lat_code_i,
    input  wire logic       high_band_i,
    // Link clock domain.
    input  wire logic       sck_i,
    input  wire logic       srst_sck_i,
    input  wire logic [2:0] family_i,
    input  wire logic       addr_done_i,
    input  wire logic       cs_end_i,
    // Results on the link clock.
    output logic [7:0]      mode_cnt_o,
    output logic [7:0]      dummy_cnt_o,
    output logic            unsupported_o,
    output logic            mode_phase_o,
    output logic            dummy_phase_o,
    output logic            data_en_o
);
    logic [2:0] cfg_m_reg;
    logic [2:0] cfg_m_next;
    logic [1:0] code_s1_reg;
    logic [1:0] code_s2_reg;
    logic       band_s1_reg;
    logic       band_s2_reg;
    logic [2:0] cfg_s3_reg;
    logic [2:0] cfg_use_reg;
    logic [2:0] cfg_use_next;
    logic [1:0] code_use;
    logic       band_use;
    logic [7:0] mode_sel;
    logic [7:0] dmy_sel;
    logic [7:0] mode_cnt_reg;
    logic [7:0] mode_cnt_next;
    logic [7:0] dummy_cnt_reg;
    logic [7:0] dummy_cnt_next;
    logic       unsup_reg;
    logic       unsup_next;
    phase_t     ph_reg;
    phase_t     ph_next;
    logic [7:0] left_reg;
    logic [7:0] left_next;

    // Launch flops in the system domain keep upstream glitches off SCK.
    always_comb begin
        cfg_m_next = {lat_code_i, high_band_i};
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            cfg_m_reg <= {LC_00, 1'b0};
        end else begin
            cfg_m_reg <= cfg_m_next;
        end
    end

    // Configuration is quasi-static; every bit is synchronised to SCK.
    always_ff @(posedge sck_i) begin
        if (srst_sck_i) begin
            code_s1_reg <= LC_00;
            code_s2_reg <= LC_00;
            band_s1_reg <= 1'b0;
            band_s2_reg <= 1'b0;
            cfg_s3_reg  <= {LC_00, 1'b0};
            cfg_use_reg <= {LC_00, 1'b0};
        end else begin
            code_s1_reg <= cfg_m_reg[2:1];
            code_s2_reg <= code_s1_reg;
            band_s1_reg <= cfg_m_reg[0];
            band_s2_reg <= band_s1_reg;
            cfg_s3_reg  <= {code_s2_reg, band_s2_reg};
            cfg_use_reg <= cfg_use_next;
        end
    end

    // A setting is used only once it has held for two SCK edges.
    // This keeps a code caught in mid-change away from the table.
    always_comb begin
        cfg_use_next = cfg_use_reg;
        if (cfg_s3_reg == {code_s2_reg, band_s2_reg}) begin
            cfg_use_next = cfg_s3_reg;
        end
        code_use = cfg_use_reg[2:1];
        band_use = cfg_use_reg[0];
    end

    // Table lookup for the selected code, band and command family.
    always_comb begin
        mode_sel = CNT_NA;
        dmy_sel  = CNT_NA;
        case (code_use)
            LC_11: begin // RULE2
                case (fam_t'(family_i))
                    FAM_READ, FAM_FAST, FAM_DOUT, FAM_QOUT: begin
                        mode_sel = MODE_NONE; // RULE1
                        dmy_sel  = DMY_NONE;
                    end
                    FAM_DIO: begin
                        mode_sel = MODE_DIO; // RULE1
                        dmy_sel  = DMY_NONE;
                    end
                    FAM_QIO: begin
                        mode_sel = MODE_QIO; // RULE1
                        dmy_sel  = DMY_QIO11;
                    end
                    default: begin
                        mode_sel = CNT_NA;
                        dmy_sel  = CNT_NA;
                    end
                endcase
            end
            LC_10: begin
                if (band_use) begin
                    if (fam_t'(family_i) == FAM_FAST) begin
                        mode_sel = MODE_NONE; // RULE6
                        dmy_sel  = DMY_STD;
                    end
                end else begin
                    case (fam_t'(family_i))
                        FAM_FAST, FAM_DOUT, FAM_QOUT: begin
                            mode_sel = MODE_NONE; // RULE5
                            dmy_sel  = DMY_STD;
                        end
                        FAM_DIO: begin
                            mode_sel = MODE_DIO; // RULE5
                            dmy_sel  = DMY_DIO10;
                        end
                        FAM_QIO: begin
                            mode_sel = MODE_QIO; // RULE5
                            dmy_sel  = DMY_QIO10;
                        end
                        default: begin
                            mode_sel = CNT_NA;
                            dmy_sel  = CNT_NA;
                        end
                    endcase
                end
            end
            LC_01: begin
                case (fam_t'(family_i))
                    FAM_FAST, FAM_DOUT, FAM_QOUT: begin
                        mode_sel = MODE_NONE; // RULE4
                        dmy_sel  = DMY_STD;
                    end
                    FAM_DIO: begin
                        mode_sel = MODE_DIO; // RULE4
                        dmy_sel  = DMY_DIO01;
                    end
                    FAM_QIO: begin
                        mode_sel = MODE_QIO; // RULE4
                        dmy_sel  = DMY_QIO01;
                    end
                    default: begin
                        mode_sel = CNT_NA;
                        dmy_sel  = CNT_NA;
                    end
                endcase
            end
            default: begin
                case (fam_t'(family_i))
                    FAM_FAST, FAM_DOUT, FAM_QOUT: begin
                        mode_sel = MODE_NONE; // RULE3
                        dmy_sel  = DMY_STD;
                    end
                    FAM_DIO: begin
                        mode_sel = MODE_DIO;
                        dmy_sel  = DMY_DIO01;
                    end
                    FAM_QIO: begin
                        mode_sel = MODE_QIO;
                        dmy_sel  = DMY_QIO01;
                    end
                    default: begin
                        mode_sel = CNT_NA;
                        dmy_sel  = CNT_NA;
                    end
                endcase
            end
        endcase
    end

    // Latch counts at the end of the address phase and pace the phases.
    always_comb begin
        mode_cnt_next  = mode_cnt_reg;
        dummy_cnt_next = dummy_cnt_reg;
        unsup_next     = unsup_reg;
        ph_next        = ph_reg;
        left_next      = left_reg;
        case (ph_reg)
            ST_IDLE: begin
                if (addr_done_i) begin
                    mode_cnt_next  = mode_sel;
                    dummy_cnt_next = dmy_sel;
                    unsup_next = (mode_sel == CNT_NA)
                              || (dmy_sel == CNT_NA); // RULE7
                    if (unsup_next) begin
                        ph_next = ST_IDLE; // RULE7
                    end else if (mode_sel != 8'h00) begin
                        ph_next   = ST_MODE; // RULE8
                        left_next = mode_sel;
                    end else if (dmy_sel != 8'h00) begin
                        ph_next   = ST_DUMMY; // RULE8
                        left_next = dmy_sel;
                    end else begin
                        ph_next = ST_DATA;
                    end
                end
            end
            ST_MODE: begin
                left_next = left_reg - 8'h01;
                if (left_reg == 8'h01) begin
                    if (dummy_cnt_reg != 8'h00) begin
                        ph_next   = ST_DUMMY; // RULE8
                        left_next = dummy_cnt_reg;
                    end else begin
                        ph_next = ST_DATA;
                    end
                end
            end
            ST_DUMMY: begin
                left_next = left_reg - 8'h01;
                if (left_reg == 8'h01) begin
                    ph_next = ST_DATA; // RULE8
                end
            end
            ST_DATA: begin
                ph_next = ST_DATA;
            end
            default: begin
                ph_next = ST_IDLE;
            end
        endcase
        if (cs_end_i) begin
            ph_next = ST_IDLE;
        end
    end

    always_ff @(posedge sck_i) begin
        if (srst_sck_i) begin
            mode_cnt_reg  <= 8'h00;
            dummy_cnt_reg <= 8'h00;
            unsup_reg     <= 1'b0;
            ph_reg        <= ST_IDLE;
            left_reg      <= 8'h00;
        end else begin
            mode_cnt_reg  <= mode_cnt_next;
            dummy_cnt_reg <= dummy_cnt_next;
            unsup_reg     <= unsup_next;
            ph_reg        <= ph_next;
            left_reg      <= left_next;
        end
    end

    // Registered outputs, one SCK after the state that they report.
    always_ff @(posedge sck_i) begin
        if (srst_sck_i) begin
            mode_cnt_o    <= 8'h00;
            dummy_cnt_o   <= 8'h00;
            unsupported_o <= 1'b0;
            mode_phase_o  <= 1'b0;
            dummy_phase_o <= 1'b0;
            data_en_o     <= 1'b0;
        end else begin
            mode_cnt_o    <= mode_cnt_reg;
            dummy_cnt_o   <= dummy_cnt_reg;
            unsupported_o <= unsup_reg;
            mode_phase_o  <= (ph_reg == ST_MODE);
            dummy_phase_o <= (ph_reg == ST_DUMMY);
            data_en_o     <= (ph_reg == ST_DATA); // RULE8
        end
    end

endmodule // read_latency_code_selector
`default_nettype wire

// ==== sim/flash_host_model.sv ====
// Host side model: ends an address phase, counts non-data clocks, ends frame.
// Assumes a free SCK; drives and samples everything on its falling edge.
`default_nettype none
module flash_host_model (
    // Observed phases.
    input  wire logic       sck_i,
    input  wire logic       mode_phase_i,
    input  wire logic       dummy_phase_i,
    input  wire logic       data_en_i,
    // Driven request.
    output logic [2:0]      family_o,
    output logic            addr_done_o,
    output logic            cs_end_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        family_o = 3'h0;
        addr_done_o = 1'b0;
        cs_end_o = 1'b0;
    end
    // The gap sets how promptly the next read follows.
    task automatic read(input logic [2:0] fam, input int gap,
                        output logic [7:0] mc, output logic [7:0] dc,
                        output logic got);
        mc = 8'h00;
        dc = 8'h00;
        got = 1'b0;
        repeat (gap) @(negedge sck_i);
        family_o = fam;
        addr_done_o = 1'b1;
        @(negedge sck_i);
        addr_done_o = 1'b0;
        repeat (24) begin
            @(negedge sck_i);
            mc = mc + {7'h00, mode_phase_i === 1'b1};
            dc = dc + {7'h00, dummy_phase_i === 1'b1};
            got = got | (data_en_i === 1'b1);
        end
        @(negedge sck_i);
        cs_end_o = 1'b1;
        @(negedge sck_i);
        cs_end_o = 1'b0;
        repeat (3) @(negedge sck_i);
    endtask
endmodule // flash_host_model
`default_nettype wire

// ==== sim/lat_sel_asserts.sv ====
// Checker for the read latency selector, on the link clock.
// Assumes the selector's own ports only; bound below.
`default_nettype none
module lat_sel_asserts (
    // System clock domain.
    input wire logic       mclk_i,
    input wire logic       srst_i,
    input wire logic [1:0] lat_code_i,
    input wire logic       high_band_i,
    // Link clock domain.
    input wire logic       sck_i,
    input wire logic       srst_sck_i,
    input wire logic [2:0] family_i,
    input wire logic       addr_done_i,
    input wire logic       cs_end_i,
    // Results.
    input wire logic [7:0] mode_cnt_o,
    input wire logic [7:0] dummy_cnt_o,
    input wire logic       unsupported_o,
    input wire logic       mode_phase_o,
    input wire logic       dummy_phase_o,
    input wire logic       data_en_o
);
    default clocking cb @(posedge sck_i);
    endclocking
    default disable iff (srst_sck_i);
    a_unsup_nodata: assert property (
        unsupported_o |-> !data_en_o && {mode_cnt_o, dummy_cnt_o} == 16'hffff)
        else $error("Unavailable read shows data or counts.");
    a_phase_onehot: assert property (
        $onehot0({mode_phase_o, dummy_phase_o, data_en_o}))
        else $error("Two phases at once.");
    a_mode_four: assert property (
        $rose(mode_phase_o) && mode_cnt_o == 8'h04
        |-> mode_phase_o [*4] ##1 !mode_phase_o)
        else $error("Mode phase not four clocks.");
    a_mode_two: assert property (
        $rose(mode_phase_o) && mode_cnt_o == 8'h02
        |-> mode_phase_o [*2] ##1 !mode_phase_o)
        else $error("Mode phase not two clocks.");
    a_dummy_eight: assert property (
        $rose(dummy_phase_o) && dummy_cnt_o == 8'h08
        |-> dummy_phase_o [*8] ##1 data_en_o)
        else $error("Dummy phase not eight clocks.");
    a_dummy_five: assert property (
        $rose(dummy_phase_o) && dummy_cnt_o == 8'h05
        |-> dummy_phase_o [*5] ##1 data_en_o)
        else $error("Dummy phase not five clocks.");
    a_dummy_one: assert property (
        $rose(dummy_phase_o) && dummy_cnt_o == 8'h01
        |-> ##1 !dummy_phase_o && data_en_o)
        else $error("Dummy phase not one clock.");
    a_mode_then: assert property (
        $fell(mode_phase_o)
        |-> (dummy_cnt_o == 8'h00 ? data_en_o : dummy_phase_o))
        else $error("Wrong phase after mode clocks.");
    a_answer_time: assert property (
        addr_done_i && !$past(addr_done_i) && !mode_phase_o
        && !dummy_phase_o && !data_en_o |-> ##2
        (mode_phase_o || dummy_phase_o || data_en_o || unsupported_o))
        else $error("No answer two clocks after the address.");
    a_counts_hold: assert property (
        data_en_o && $past(data_en_o)
        |-> $stable(mode_cnt_o) && $stable(dummy_cnt_o))
        else $error("Counts moved during data.");
endmodule // lat_sel_asserts
bind read_latency_code_selector lat_sel_asserts chk_u (.mclk_i, .srst_i,
    .lat_code_i, .high_band_i, .sck_i, .srst_sck_i, .family_i, .addr_done_i,
    .cs_end_i, .mode_cnt_o, .dummy_cnt_o, .unsupported_o, .mode_phase_o,
    .dummy_phase_o, .data_en_o);
`default_nettype wire

// ==== sim/read_latency_code_selector_test.sv ====
// Bench for the read latency selector: table sweep, then random reads.
// Assumes the host model on the link side and a free-running SCK.
`default_nettype none
module read_latency_code_selector_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic       mclk_i = 1'b0;
    logic       sck_i = 1'b0;
    logic       srst_i = 1'b1;
    logic       srst_sck_i = 1'b1;
    logic [1:0] lat_code_i = 2'h0;
    logic       high_band_i = 1'b0;
    logic [2:0] family_i;
    logic       addr_done_i;
    logic       cs_end_i;
    logic [7:0] mode_cnt_o;
    logic [7:0] dummy_cnt_o;
    logic       unsupported_o;
    logic       mode_phase_o;
    logic       dummy_phase_o;
    logic       data_en_o;
    logic [1:0] rc;
    int         fails = 0;
    int         samples_checked = 0;
    int         cycles = 0;
    int         seed = 91;
    initial forever #4 mclk_i = ~mclk_i;
    initial begin
        #0.5;
        forever #15 sck_i = ~sck_i;
    end
    read_latency_code_selector dut_u (.mclk_i, .srst_i, .lat_code_i,
        .high_band_i, .sck_i, .srst_sck_i, .family_i, .addr_done_i,
        .cs_end_i, .mode_cnt_o, .dummy_cnt_o, .unsupported_o, .mode_phase_o,
        .dummy_phase_o, .data_en_o);
    flash_host_model host_u (.sck_i, .mode_phase_i(mode_phase_o),
        .dummy_phase_i(dummy_phase_o), .data_en_i(data_en_o),
        .family_o(family_i), .addr_done_o(addr_done_i), .cs_end_o(cs_end_i));
    task automatic summarize();
        $display("fails=%0d samples_checked=%0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            summarize();
        end
    end
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Mode count in the upper byte, dummy count in the lower byte.
    function automatic logic [15:0] exp_cnt(logic [1:0] c, logic hb,
                                            logic [2:0] f);
        if (f > 3'h5)
            return 16'hffff;
        if (hb)
            return (f == 3'h1) ? 16'h0008 : 16'hffff;
        if (c == 2'h3)
            return f == 3'h4 ? 16'h0400 :
                   f == 3'h5 ? 16'h0201 : 16'h0000;
        if (f == 3'h0)
            return 16'hffff;
        if (f < 3'h4)
            return 16'h0008;
        if (c == 2'h2)
            return f == 3'h4 ? 16'h0402 : 16'h0205;
        return f == 3'h4 ? 16'h0401 : 16'h0204;
    endfunction
    task automatic run_one(input logic [1:0] c, input logic hb,
                           input logic [2:0] f);
        logic [15:0] e;
        logic [7:0]  mc;
        logic [7:0]  dc;
        logic        got;
        logic        sup;
        @(negedge mclk_i);
        lat_code_i = c;
        high_band_i = hb;
        e = exp_cnt(c, hb, f);
        sup = (e != 16'hffff);
        host_u.read(f, 6 + {$random(seed)} % 4, mc, dc, got);
        check("counts", {mode_cnt_o, dummy_cnt_o}, e);
        check("clocks", {mc, dc}, sup ? e : 16'h0000);
        check("data", {15'h0, got}, {15'h0, sup});
        check("unsup", {15'h0, unsupported_o}, {15'h0, ~sup});
        check("end", {15'h0, data_en_o}, 16'h0000);
    endtask
    initial begin
        repeat (20) @(negedge mclk_i);
        srst_i = 1'b0;
        srst_sck_i = 1'b0;
        for (int i = 0; i < 30; i++)
            run_one(i < 24 ? 2'(i / 6) : 2'h2, i >= 24, 3'(i % 6));
        @(negedge sck_i);
        srst_sck_i = 1'b1;
        repeat (3) @(negedge sck_i);
        check("reset", {mode_cnt_o, dummy_cnt_o}, 16'h0000);
        srst_sck_i = 1'b0;
        run_one(2'h1, 1'b0, 3'h7);
        for (int i = 0; i < 20; i++) begin
            rc = 2'($random(seed));
            run_one(rc, rc == 2'h2 && $random(seed) % 2 != 0,
                    3'({$random(seed)} % 6));
        end
        summarize();
    end
endmodule // read_latency_code_selector_test
`default_nettype wire
